// [ras_slave.sv]
// ras_slave: two-wire serial slave giving a master access to 16-bit
// control registers and launching the frequency pull after a delay
// assumes open-drain pads outside, a 10 MHz clk_i, scl as link clock
`timescale 1ns/10ps
module ras_slave
    import ras_pkg::*;
(
    input logic clk_i,
    input logic rstn_i,
    input logic scl_i,
    input logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input logic addr_mode_i,
    input logic [3:0] addr_code_i,
    input logic address_select_pin_i,
    output ras_pull_s freq_pull_word_o,
    output logic pull_start_o
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] pin_r;
    logic [2:0] pin_prev_r;
    logic scl_s, sda_s, scl_p, sda_p, asel_s;
    logic scl_rise, start_evt, stop_evt;
    logic bit_rise, byte_done, ack_bit, is_read, addr_hit, ack_now;
    logic strap_taken_r, mode_r;
    logic [3:0] code_r;
    logic [6:0] own_addr;
    ras_phase_e phase_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r, byte_in, tx_byte, ptr_r, msb_r;
    logic [2:0] tx_idx;
    logic drive_low_r;
    logic sent_r, host_ack;
    ras_wr_s mem_wr;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic [15:0] lower_r;
    ras_pull_s pend_word_r;
    logic pend_r;
    logic [10:0] dly_r;
    logic [10:0] lat_r;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    assign pin_raw = {address_select_pin_i, sda_i, scl_i};

    // three stages; a level counts once stages two and three agree
    for (genvar g = 0; g < 3; g++)
    begin : g_sync
        always_ff @(posedge clk_i or negedge rstn_i)
        begin
            if (!rstn_i)
            begin
                sync1_r[g] <= PIN_IDLE[g];
                sync2_r[g] <= PIN_IDLE[g];
                sync3_r[g] <= PIN_IDLE[g];
                pin_r[g] <= PIN_IDLE[g];
                pin_prev_r[g] <= PIN_IDLE[g];
            end
            else
            begin
                sync1_r[g] <= pin_raw[g];
                sync2_r[g] <= sync1_r[g];
                sync3_r[g] <= sync2_r[g];
                if (sync2_r[g] == sync3_r[g])
                    pin_r[g] <= sync3_r[g];
                pin_prev_r[g] <= pin_r[g];
            end
        end
    end

    assign scl_s = pin_r[0];
    assign sda_s = pin_r[1];
    assign asel_s = pin_r[2];
    assign scl_p = pin_prev_r[0];
    assign sda_p = pin_prev_r[1];

    // edge and condition decode on the filtered lines
    assign scl_rise = scl_s & ~scl_p;
    assign start_evt = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_evt = scl_s & scl_p & ~sda_p & sda_s;

    // ------------------------------------------------------------
    // device address
    // ------------------------------------------------------------
    // straps are static; catch them once, just after reset release
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_taken_r <= 1'b0;
            mode_r <= ADDR_MODE_FACTORY;
            code_r <= 4'h0;
        end
        else if (!strap_taken_r)
        begin
            strap_taken_r <= 1'b1;
            mode_r <= addr_mode_i;
            code_r <= addr_code_i;
        end
    end

    // factory mode never looks at the select pin
    always_comb
    begin
        if (mode_r == ADDR_MODE_FACTORY)
            own_addr = {ADDR_FACTORY_HI, code_r};
        else
            own_addr = asel_s ? ADDR_PIN_HI : ADDR_PIN_LO;
    end

    // ------------------------------------------------------------
    // bit framing
    // ------------------------------------------------------------
    assign bit_rise = scl_rise && (phase_r != PH_IDLE);
    assign byte_done = bit_rise && (cnt_r == BIT_LAST);
    assign ack_bit = bit_rise && (cnt_r == BIT_ACK);
    assign byte_in = {shift_r[6:0], sda_s};
    assign is_read = (phase_r == PH_RMSB) || (phase_r == PH_RLSB);
    assign addr_hit = (byte_in[7:1] == own_addr);
    assign tx_byte = (phase_r == PH_RLSB) ? rd_data[7:0] : rd_data[15:8];
    assign tx_idx = 3'h6 - cnt_r[2:0];

    // ack for every byte received in the address, pointer or write phases, except a foreign address
    assign ack_now = ((phase_r == PH_ADDR) && addr_hit) || (phase_r == PH_PTR)
        || (phase_r == PH_WMSB) || (phase_r == PH_WLSB);

    // master pulled the ninth bit low after a byte we sent: read is over
    assign host_ack = ack_bit && sent_r && !sda_s;

    // bit counter 0..7 data, 8 acknowledge; shifts msb first
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end
        else if (start_evt || stop_evt)
            cnt_r <= 4'h0;
        else if (bit_rise)
        begin
            cnt_r <= (cnt_r == BIT_ACK) ? 4'h0 : cnt_r + 4'h1;
            if (cnt_r != BIT_ACK)
                shift_r <= byte_in;
        end
    end

    // marks a byte that we transmitted, so our own address ack is
    // never taken for the master's acknowledge
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            sent_r <= 1'b0;
        else if (start_evt || stop_evt)
            sent_r <= 1'b0;
        else if (byte_done)
            sent_r <= is_read;
    end

    // ------------------------------------------------------------
    // transaction phase
    // ------------------------------------------------------------
    // a start in any phase restarts with the address byte
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            phase_r <= PH_IDLE;
        else if (stop_evt)
            phase_r <= PH_IDLE;
        else if (start_evt)
            phase_r <= PH_ADDR;
        else if (host_ack)
            phase_r <= PH_IGNORE;
        else if (byte_done)
        begin
            unique case (phase_r)
                PH_ADDR:
                    if (!addr_hit)
                        phase_r <= PH_IGNORE;
                    else if (byte_in[0] == RW_READ)
                        phase_r <= PH_RMSB;
                    else
                        phase_r <= PH_PTR;
                PH_PTR: phase_r <= PH_WMSB;
                PH_WMSB: phase_r <= PH_WLSB;
                PH_WLSB: phase_r <= PH_WMSB;
                PH_RMSB: phase_r <= PH_RLSB;
                PH_RLSB: phase_r <= PH_RMSB;
                PH_IDLE, PH_IGNORE: phase_r <= phase_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // data line drive
    // ------------------------------------------------------------
    // decided on each rising clock, handed to the link flop at the fall
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            drive_low_r <= 1'b0;
        else if (start_evt || stop_evt)
            drive_low_r <= 1'b0;
        else if (bit_rise)
        begin
            if (cnt_r == BIT_LAST)
                drive_low_r <= ack_now;
            else if (cnt_r == BIT_ACK)
                drive_low_r <= is_read & ~tx_byte[7] & ~host_ack;
            else
                drive_low_r <= is_read & ~tx_byte[tx_idx];
        end
    end

    // link side: the pad enable changes only at the falling clock, so
    // data never moves while the clock is high; drive_low_r is settled
    // by then as it moves only right after a rising edge, a start or a stop is seen
    // limitation: the high phase must outlast the five-cycle sync and decode delay
    always_ff @(negedge scl_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sda_oe_o <= 1'b0;
            sda_o <= 1'b0;
        end
        else
        begin
            sda_oe_o <= drive_low_r;
            sda_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register pointer and storage
    // ------------------------------------------------------------
    // pointer survives between transactions so bare reads resume
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ptr_r <= PTR_RESET;
        else if (byte_done && (phase_r == PH_PTR))
            ptr_r <= byte_in;
        else if (byte_done && ((phase_r == PH_WLSB) || (phase_r == PH_RLSB)))
            ptr_r <= ptr_r + 8'h01;
    end

    // high byte waits for its partner; a lone one is dropped at stop
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            msb_r <= 8'h00;
        else if (byte_done && (phase_r == PH_WMSB))
            msb_r <= byte_in;
    end

    // word written when its low byte arrives
    always_comb
    begin
        mem_wr.we = byte_done && (phase_r == PH_WLSB);
        mem_wr.addr = ptr_r;
        mem_wr.data = {msb_r, byte_in};
    end

    // fetch at a read address match and at each read advance
    assign rd_en = byte_done && (((phase_r == PH_ADDR) && addr_hit && byte_in[0])
        || (phase_r == PH_RLSB));
    assign rd_addr = (phase_r == PH_RLSB) ? ptr_r + 8'h01 : ptr_r;

    ras_regmem u_mem
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .wr_i(mem_wr),
        .rd_en_i(rd_en),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data)
    );

    // ------------------------------------------------------------
    // frequency pull launch
    // ------------------------------------------------------------
    // lower word only waits; the upper word write arms the delay
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            lower_r <= WORD_RESET;
            pend_word_r <= '0;
            pend_r <= 1'b0;
            dly_r <= 11'h000;
        end
        else
        begin
            if (mem_wr.we && (mem_wr.addr == REG_LOWER))
                lower_r <= mem_wr.data;
            if (mem_wr.we && (mem_wr.addr == REG_UPPER))
            begin
                pend_word_r <= {mem_wr.data[UPPER_W-1:0], lower_r};
                pend_r <= 1'b1;
                dly_r <= FREQ_CHANGE_CNT - 11'h001;
            end
            else if (pend_r)
            begin
                if (dly_r == 11'h001)
                    pend_r <= 1'b0;
                dly_r <= dly_r - 11'h001;
            end
        end
    end

    // a rewrite during the wait restarts it with the newest word
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            freq_pull_word_o <= '0;
            pull_start_o <= 1'b0;
        end
        else
        begin
            pull_start_o <= 1'b0;
            // only an upper word rewrite restarts the wait; other writes must not eat it
            if (pend_r && (dly_r == 11'h001) && !(mem_wr.we && (mem_wr.addr == REG_UPPER)))
            begin
                freq_pull_word_o <= pend_word_r;
                pull_start_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // cycles since the last upper word write, saturating
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            lat_r <= '1;
        else if (mem_wr.we && (mem_wr.addr == REG_UPPER))
            lat_r <= 11'h001;
        else if (lat_r != '1)
            lat_r <= lat_r + 11'h001;
    end

    a_start_restart: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        start_evt |=> (phase_r == PH_ADDR) && (cnt_r == 4'h0) && !drive_low_r)
        else $error("start did not restart address phase");

    a_stop_release: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        stop_evt |=> (phase_r == PH_IDLE) && !drive_low_r)
        else $error("stop did not release the data line");

    a_addr_nack: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (byte_done && (phase_r == PH_ADDR) && !addr_hit)
            |=> !drive_low_r && (phase_r == PH_IGNORE))
        else $error("foreign address was acknowledged");

    a_write_ack: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (byte_done && (phase_r inside {PH_PTR, PH_WMSB, PH_WLSB}))
            |=> drive_low_r && (cnt_r == BIT_ACK))
        else $error("received byte not acknowledged");

    a_read_continue: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (ack_bit && is_read && sda_s) |=> is_read && (drive_low_r == !tx_byte[7]))
        else $error("read did not go on after a nack");

    a_ptr_wrap: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (byte_done && (phase_r == PH_WLSB) && (ptr_r == '1)) |=> (ptr_r == PTR_RESET))
        else $error("pointer did not wrap to zero");

    a_word_order: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (byte_done && (phase_r == PH_WMSB))
            |=> (phase_r == PH_WLSB) && (msb_r == $past(byte_in)))
        else $error("high byte not held first");

    a_pull_latency: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        pull_start_o |-> (lat_r == FREQ_CHANGE_CNT) && (lat_r <= FREQ_CHANGE_MAX_CNT))
        else $error("pull start off its delay");

    a_lower_quiet: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (mem_wr.we && (mem_wr.addr == REG_LOWER) && !pend_r) |=> !pend_r && !pull_start_o)
        else $error("lower word write launched a pull");

    a_read_release: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        host_ack |=> !drive_low_r && (phase_r == PH_IGNORE))
        else $error("read went on after the master acknowledged");

    a_pin_ignored: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (strap_taken_r && (mode_r == ADDR_MODE_FACTORY) && $changed(asel_s))
            |-> $stable(own_addr))
        else $error("select pin moved a factory address");

    c_upper_write: cover property (
        @(posedge clk_i) disable iff (!rstn_i) pull_start_o);

    c_read_word: cover property (
        @(posedge clk_i) disable iff (!rstn_i) byte_done && (phase_r == PH_RLSB));

    c_repeated_start: cover property (
        @(posedge clk_i) disable iff (!rstn_i) start_evt && (phase_r != PH_IDLE));

    c_read_nack: cover property (
        @(posedge clk_i) disable iff (!rstn_i) ack_bit && is_read && sda_s);
endmodule // ras_slave

// [ras_pkg.sv]
// ras_pkg: constants and types shared by the two-wire register slave
// assumes a 10 MHz system clock and a serial clock of at most 1 Mbit/s
package ras_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 100;
    localparam int FREQ_CHANGE_LATENCY_US = 103;
    localparam int FREQ_CHANGE_LATENCY_MAX_US = 140;
    // longest-time figures round down to whole cycles
    localparam int FREQ_CHANGE_CYC = FREQ_CHANGE_LATENCY_US * 1000 / SYS_CLK_PERIOD_NS;
    localparam int FREQ_CHANGE_MAX_CYC = FREQ_CHANGE_LATENCY_MAX_US * 1000 / SYS_CLK_PERIOD_NS;
    localparam logic [10:0] FREQ_CHANGE_CNT = 11'(FREQ_CHANGE_CYC);
    localparam logic [10:0] FREQ_CHANGE_MAX_CNT = 11'(FREQ_CHANGE_MAX_CYC);

    // ------------------------------------------------------------
    // addressing and framing
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_FACTORY_HI = 3'h6;
    localparam logic [6:0] ADDR_PIN_LO = 7'h62;
    localparam logic [6:0] ADDR_PIN_HI = 7'h6a;
    localparam logic ADDR_MODE_FACTORY = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [7:0] REG_LOWER = 8'h00;
    localparam logic [7:0] REG_UPPER = 8'h01;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [2:0] PIN_IDLE = 3'h3;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int UPPER_W = 10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PH_IDLE, PH_ADDR, PH_PTR, PH_WMSB, PH_WLSB, PH_RMSB, PH_RLSB, PH_IGNORE
    } ras_phase_e;

    typedef struct packed
    {
        logic we;
        logic [7:0] addr;
        logic [15:0] data;
    } ras_wr_s;

    typedef struct packed
    {
        logic [UPPER_W-1:0] upper;
        logic [15:0] lower;
    } ras_pull_s;
endpackage

// [ras_regmem.sv]
// ras_regmem: 256 x 16 register store with a registered read port
// assumes one write or one read per cycle from the slave core
`timescale 1ns/10ps
module ras_regmem
    import ras_pkg::*;
(
    input logic clk_i,
    input logic rstn_i,
    input ras_wr_s wr_i,
    input logic rd_en_i,
    input logic [7:0] rd_addr_i,
    output logic [15:0] rd_data_o
);
    logic [15:0] mem_r [0:255];
    logic [255:0] written_r;

    // array holds no reset; never-written entries read as zero instead
    always_ff @(posedge clk_i)
    begin
        if (wr_i.we)
            mem_r[wr_i.addr] <= wr_i.data;
    end

    // valid bit per entry
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            written_r <= '0;
        else if (wr_i.we)
            written_r[wr_i.addr] <= 1'b1;
    end

    // read data come out of a register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rd_data_o <= WORD_RESET;
        else if (rd_en_i)
            rd_data_o <= written_r[rd_addr_i] ? mem_r[rd_addr_i] : WORD_RESET;
    end
endmodule // ras_regmem

// [ras_master_model.sv]
// ras_master_model: behavioural two-wire bus master for the slave bench
// assumes clk_i at 10 MHz; one scl period is ten clk cycles (1 Mbit/s)
`timescale 1ns/10ps
module ras_master_model
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    // clock stands high and data is released outside frames
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // one bit: data moves mid-low, sampled late in the high phase
    task automatic bit_x(input logic b, output logic r);
        repeat (2) @(posedge clk_i);
        sda_pull_o <= !b;
        // high phase of six cycles: the slave decides five cycles after a rise
        repeat (2) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        r = sda_i;
        @(posedge clk_i);
        scl_o <= 1'b0;
    endtask

    // start or repeated start: free data, raise clock, then pull data
    task automatic start();
        repeat (2) @(posedge clk_i);
        sda_pull_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        sda_pull_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask

    // stop; also used to give up after a refused address
    task automatic stop();
        repeat (2) @(posedge clk_i);
        sda_pull_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        sda_pull_o <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask

    // write a byte msb first and return 1 if the slave acknowledged it
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask

    // read a byte; a low ack_i leaves a not-acknowledge
    task automatic rd_byte(input logic ack_i, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(!ack_i, r);
    endtask
endmodule // ras_master_model

// [tb_ras_slave.sv]
// tb_ras_slave: self-checking bench for the two-wire register slave
// assumes the master model drives scl at 1 Mbit/s from the 10 MHz clock
`timescale 1ns/10ps
module tb_ras_slave
    import ras_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic addr_mode = 1'b0;
    logic [3:0] addr_code = 4'h0;
    logic sel_pin = 1'b0;
    logic scl, sda_pull, sda_o, sda_oe, pull_start, a;
    logic [7:0] b0, b1;
    ras_pull_s pull_word;
    int errors = 0;
    int tests_run = 0;
    // open-drain data line with a pull-up
    wire logic sda = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    always #50 clk_i = ~clk_i;

    ras_master_model u_ras_master_model (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
        .sda_pull_o(sda_pull));
    ras_slave u_ras_slave (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_mode_i(addr_mode), .addr_code_i(addr_code),
        .address_select_pin_i(sel_pin), .freq_pull_word_o(pull_word),
        .pull_start_o(pull_start));

    // ----------------------------------------
    // compare and helper tasks
    // ----------------------------------------
    task automatic chk_ack(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic chk_val(input string n, input logic [25:0] e, input logic [25:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // straps must be steady when reset lets go
    task automatic rst(input logic m, input logic [3:0] c);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        addr_mode <= m;
        addr_code <= c;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wb(input logic [7:0] d, input logic e);
        u_ras_master_model.wr_byte(d, a);
        chk_ack("ack", e, a);
    endtask
    // read one register; the msb is refused so the lsb follows, and lst
    // acknowledges the lsb, which must end the read and free the line
    task automatic rw(input logic [15:0] e, input logic lst);
        u_ras_master_model.rd_byte(1'b0, b0);
        u_ras_master_model.rd_byte(lst, b1);
        chk_val("word", {10'h0, e}, {10'h0, b0, b1});
        @(negedge clk_i);
        if (lst)
            chk_ack("release", 1'b0, sda_oe);
    endtask
    // addresses for the select pin, both levels, matching and not
    task automatic t_pin();
        rst(1'b1, 4'h0);
        for (int i = 0; i < 4; i++)
        begin
            sel_pin <= i[1];
            repeat (4) @(posedge clk_i);
            u_ras_master_model.start();
            wb(i[0] ? 8'hd4 : 8'hc4, i[0] == i[1]);
            u_ras_master_model.stop();
        end
    endtask
    // every stored code; the select pin toggles but must not matter
    task automatic t_factory();
        for (int c = 0; c < 16; c++)
        begin
            sel_pin <= c[0];
            rst(1'b0, c[3:0]);
            u_ras_master_model.start();
            wb({3'h6, c[3:0], 1'b0}, 1'b1);
            u_ras_master_model.stop();
            u_ras_master_model.start();
            wb({3'h6, c[3:0] ^ 4'h1, 1'b0}, 1'b0);
            u_ras_master_model.stop();
        end
    endtask
    // lower then upper word back to back, pull must follow in time
    task automatic t_write_pull();
        int n;
        n = 0;
        sel_pin <= 1'b0;
        rst(1'b0, 4'ha);
        u_ras_master_model.start();
        wb(8'hd4, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h12, 1'b1);
        wb(8'h34, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'h55, 1'b1);
        while (pull_start !== 1'b1 && n < FREQ_CHANGE_MAX_CYC)
        begin
            @(negedge clk_i); // mid-cycle, where the one-cycle pulse is settled
            n++;
        end
        chk_ack("pull_start", 1'b1, pull_start);
        chk_val("pull_word", {10'h155, 16'h1234}, pull_word);
        wb(8'h80, 1'b1);
        wb(8'h00, 1'b1);
        u_ras_master_model.stop();
    endtask
    // pointer wrap on write and read, repeated start, nack on read
    task automatic t_read();
        u_ras_master_model.start();
        wb(8'hd4, 1'b1);
        wb(8'hff, 1'b1);
        wb(8'hab, 1'b1);
        wb(8'hcd, 1'b1);
        u_ras_master_model.stop();
        u_ras_master_model.start();
        wb(8'hd5, 1'b1);
        rw(16'h1234, 1'b0);
        rw(16'h0155, 1'b1);
        u_ras_master_model.stop();
        u_ras_master_model.start();
        wb(8'hd4, 1'b1);
        wb(8'hff, 1'b1);
        u_ras_master_model.start();
        wb(8'hd5, 1'b1);
        rw(16'habcd, 1'b0);
        rw(16'h1234, 1'b1);
        u_ras_master_model.stop();
    endtask
    // a lone upper byte cut off by stop is dropped
    task automatic t_abort();
        u_ras_master_model.start();
        wb(8'hd4, 1'b1);
        wb(8'hfe, 1'b1);
        wb(8'h77, 1'b1);
        u_ras_master_model.stop();
        u_ras_master_model.start();
        wb(8'hd4, 1'b1);
        wb(8'hfe, 1'b1);
        u_ras_master_model.start();
        wb(8'hd5, 1'b1);
        rw(16'h0000, 1'b1);
        u_ras_master_model.stop();
    endtask

    // watchdog: about three times the expected run length
    initial
    begin
        repeat (30000) @(posedge clk_i);
        errors++;
        end_sim();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        t_pin();
        t_factory();
        t_write_pull();
        t_read();
        t_abort();
        end_sim();
    end
endmodule // tb_ras_slave
